// ---- core/fsb_pkg.sv ----
package fsb_pkg;

	// ----------------------------------------
	// Opcodes of the four skip instructions.
	// ----------------------------------------
	localparam logic [9:0] FSB_OPC_CONV = 10'h287;
	localparam logic [9:0] FSB_OPC_PIN = 10'h03A;
	localparam logic [9:0] FSB_OPC_STBY = 10'h003;
	localparam logic [9:0] FSB_OPC_SER = 10'h288;

	// ----------------------------------------
	// Control bit positions.
	// ----------------------------------------
	localparam int FSB_CONV_EN_BIT = 2;
	localparam int FSB_SER_EN_BIT = 3;
	localparam int FSB_LVL_SEL_BIT = 2;

	// ----------------------------------------
	// Register offsets (byte addresses).
	// ----------------------------------------
	localparam logic [7:0] FSB_REG_IEB = 8'h00;
	localparam logic [7:0] FSB_REG_EPC = 8'h04;
	localparam logic [7:0] FSB_REG_FLG = 8'h08;
	localparam logic [7:0] FSB_REG_IST = 8'h0C;
	localparam logic [7:0] FSB_REG_IMK = 8'h10;

	// ----------------------------------------
	// Field positions of flag and event registers.
	// ----------------------------------------
	localparam int FSB_FLG_CONV = 0;
	localparam int FSB_FLG_SER = 1;
	localparam int FSB_FLG_STBY = 2;
	localparam int FSB_FLG_PIN = 3;
	localparam int FSB_EV_SKIP = 0;
	localparam int FSB_EV_CONV = 1;
	localparam int FSB_EV_SER = 2;
	localparam int FSB_EV_N = 3;

	// ----------------------------------------
	// Values after reset.
	// ----------------------------------------
	localparam logic [3:0] FSB_IEB_RST = 4'h0;
	localparam logic [3:0] FSB_EPC_RST = 4'h0;
	localparam logic [2:0] FSB_EV_RST = 3'h0;

	// One-hot decode of the instruction being executed.
	typedef struct packed {
		logic conv;
		logic pin;
		logic stby;
		logic ser;
	} fsb_dec_t;

	// Sequencing state: running or squashing the next fetch.
	typedef enum logic [0:0] {
		FSB_ST_RUN = 1'b0,
		FSB_ST_SKIP = 1'b1
	} fsb_state_t;

endpackage : fsb_pkg

// ---- core/fsb_decode.sv ----
`timescale 1ns/1ps
module fsb_decode
	import fsb_pkg::*;
(
	input wire logic exec_en,
	input wire logic [9:0] instr_word,
	output fsb_dec_t dec
);

	// ----------------------------------------
	// Opcode match.
	// ----------------------------------------

	// Each field is high only for an instruction that really executes.
	assign dec.conv = exec_en && (instr_word == FSB_OPC_CONV);
	assign dec.pin = exec_en && (instr_word == FSB_OPC_PIN);
	assign dec.stby = exec_en && (instr_word == FSB_OPC_STBY);
	assign dec.ser = exec_en && (instr_word == FSB_OPC_SER);

endmodule : fsb_decode

// ---- core/fsb_flag.sv ----
`timescale 1ns/1ps
module fsb_flag (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic set,
	input wire logic clr,
	output logic flag_q
);

	// ----------------------------------------
	// Flag storage.
	// ----------------------------------------

	// Next value: an instruction clear beats a peripheral set in the same cycle.
	logic flag_d;
	assign flag_d = clr ? 1'b0 : (set ? 1'b1 : flag_q);

	// The flag changes at the end of the executing cycle.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else if (clk_en) begin
			flag_q <= flag_d;
		end
	end

endmodule : fsb_flag

// ---- core/fsb_unit.sv ----
// Overview of operation
// - Conversion opcode skips when enabled flag set.
// - Conversion opcode clears flag when enable low.
// - Conversion enable high makes opcode a no-op.
// - Conversion enable is bit 2 of B.
// - Pin opcode skips on low pin, select low.
// - Select high: skip on high pin.
// - Level select is bit 2 of polarity.
// - Standby opcode skips on flag, keeps it.
// - Serial opcode skips when enabled flag set.
// - Serial opcode clears flag when enable low.
// - Serial enable high makes opcode a no-op.
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module fsb_unit
	import fsb_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Program sequencer side.
	input wire logic instr_valid,
	input wire logic [9:0] instr_word,
	input wire logic standby_indicator,
	output logic skip_request,
	output logic skip_pending,
	// Peripheral flag side.
	input wire logic conversion_set,
	input wire logic serial_set,
	input wire logic external_request_pin,
	output logic conversion_done_flag,
	output logic serial_done_flag,
	output logic conversion_clear,
	output logic serial_clear,
	output logic irq
);

	// ----------------------------------------
	// Register state.
	// ----------------------------------------

	// Interrupt enable register B and edge polarity control.
	logic [3:0] ieb_q;
	logic [3:0] epc_q;
	// Sticky event status and its mask.
	logic [FSB_EV_N-1:0] ist_q;
	logic [FSB_EV_N-1:0] imk_q;
	// Bus data phase tracking.
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	// Outputs toward sequencer and peripherals.
	logic skip_request_q;
	logic conversion_clear_q;
	logic serial_clear_q;
	logic irq_q;
	// Pin synchroniser.
	logic pin_meta_q;
	logic pin_sync_q;
	// Sequencing state.
	fsb_state_t state_q;
	fsb_state_t state_d;

	// ----------------------------------------
	// Pin synchroniser.
	// ----------------------------------------

	// Two flops bring the asynchronous request pin onto the clock.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else if (clk_en) begin
			pin_meta_q <= external_request_pin;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ----------------------------------------
	// Decode and skip conditions.
	// ----------------------------------------

	// An instruction executes only when it is not being squashed.
	wire exec_en = clk_en && instr_valid && (state_q == FSB_ST_RUN);
	fsb_dec_t dec;

	// Opcode decoder.
	fsb_decode u_decode (
		.exec_en(exec_en),
		.instr_word(instr_word),
		.dec(dec)
	);

	wire conv_irq_enable = ieb_q[FSB_CONV_EN_BIT];
	wire serial_irq_enable = ieb_q[FSB_SER_EN_BIT];
	wire input_level_select = epc_q[FSB_LVL_SEL_BIT];

	wire conv_act = dec.conv && !conv_irq_enable;
	wire ser_act = dec.ser && !serial_irq_enable;

	wire conv_skip = conv_act && conversion_done_flag;
	wire pin_match = input_level_select ? pin_sync_q : !pin_sync_q;
	wire pin_skip = dec.pin && pin_match;
	wire stby_skip = dec.stby && standby_indicator;
	wire ser_skip = ser_act && serial_done_flag;
	wire skip_now = conv_skip || pin_skip || stby_skip || ser_skip;

	// ----------------------------------------
	// Skip sequencing.
	// ----------------------------------------

	// A skip arms the squash; the next fetched word is then dropped.
	always_comb begin
		state_d = state_q;
		case (state_q)
			FSB_ST_RUN: begin
				if (skip_now) begin
					state_d = FSB_ST_SKIP;
				end
			end
			FSB_ST_SKIP: begin
				if (clk_en && instr_valid) begin
					state_d = FSB_ST_RUN;
				end
			end
			default: begin
				state_d = FSB_ST_RUN;
			end
		endcase
	end

	// State register and the one-cycle skip and clear strobes.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= FSB_ST_RUN;
			skip_request_q <= 1'b0;
			conversion_clear_q <= 1'b0;
			serial_clear_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			skip_request_q <= skip_now;
			conversion_clear_q <= conv_act;
			serial_clear_q <= ser_act;
		end
	end

	// ----------------------------------------
	// Flags held for the peripherals.
	// ----------------------------------------

	fsb_flag u_conv_flag (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.set(conversion_set),
		.clr(conv_act),
		.flag_q(conversion_done_flag)
	);

	fsb_flag u_ser_flag (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.set(serial_set),
		.clr(ser_act),
		.flag_q(serial_done_flag)
	);

	// ----------------------------------------
	// AHB-Lite slave.
	// ----------------------------------------

	// Address phase accepted; only the low byte selects a register.
	wire ahb_go = hsel && htrans[1] && hready;
	wire [7:0] a_addr = haddr[7:0];
	wire [31:0] flg_word = {28'h000_0000, pin_sync_q, standby_indicator,
		serial_done_flag, conversion_done_flag};
	wire [31:0] rd_mux = (a_addr == FSB_REG_IEB) ? {28'h000_0000, ieb_q} :
		(a_addr == FSB_REG_EPC) ? {28'h000_0000, epc_q} :
		(a_addr == FSB_REG_FLG) ? flg_word :
		(a_addr == FSB_REG_IST) ? {29'h0000_0000, ist_q} :
		(a_addr == FSB_REG_IMK) ? {29'h0000_0000, imk_q} : 32'h0000_0000;

	// Data phase write strobes per register.
	wire wr_ieb = wr_pend_q && (wr_addr_q == FSB_REG_IEB);
	wire wr_epc = wr_pend_q && (wr_addr_q == FSB_REG_EPC);
	wire wr_ist = wr_pend_q && (wr_addr_q == FSB_REG_IST);
	wire wr_imk = wr_pend_q && (wr_addr_q == FSB_REG_IMK);

	// Zero-wait-state slave: read data is registered at the address phase.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			wr_pend_q <= ahb_go && hwrite;
			wr_addr_q <= a_addr;
			hreadyout_q <= 1'b1;
			hrdata_q <= (ahb_go && !hwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Control registers written in the data phase.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ieb_q <= FSB_IEB_RST;
			epc_q <= FSB_EPC_RST;
			imk_q <= FSB_EV_RST;
		end else if (clk_en) begin
			if (wr_ieb) begin
				ieb_q <= hwdata[3:0];
			end
			if (wr_epc) begin
				epc_q <= hwdata[3:0];
			end
			if (wr_imk) begin
				imk_q <= hwdata[FSB_EV_N-1:0];
			end
		end
	end

	// ----------------------------------------
	// Interrupt status.
	// ----------------------------------------

	// Events: skip taken, conversion flag cleared, serial flag cleared.
	wire [FSB_EV_N-1:0] ev_set = {ser_act, conv_act, skip_now};
	wire [FSB_EV_N-1:0] ev_clr = wr_ist ? hwdata[FSB_EV_N-1:0] : FSB_EV_RST;
	// A new event wins over a write-one-to-clear in the same cycle.
	wire [FSB_EV_N-1:0] ist_d = (ist_q & ~ev_clr) | ev_set;

	// Sticky status and the registered level interrupt.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ist_q <= FSB_EV_RST;
			irq_q <= 1'b0;
		end else if (clk_en) begin
			ist_q <= ist_d;
			irq_q <= |(ist_d & imk_q);
		end
	end

	// ----------------------------------------
	// Output wiring.
	// ----------------------------------------

	// Every output comes from a flop, except hresp, which is tied low.
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign skip_request = skip_request_q;
	assign skip_pending = (state_q == FSB_ST_SKIP);
	assign conversion_clear = conversion_clear_q;
	assign serial_clear = serial_clear_q;
	assign irq = irq_q;

	// ----------------------------------------
	// Checks.
	// ----------------------------------------

	// Conversion skip follows the enabled set flag.
	chk_conv_skip_taken: assert property (
		@(posedge clock) disable iff (!rst_n)
		(dec.conv && !ieb_q[FSB_CONV_EN_BIT] && conversion_done_flag)
		|=> (skip_request && skip_pending))
		else $error("conversion skip not taken");

	// Conversion flag reads zero after the opcode with enable low.
	chk_conv_flag_clear: assert property (
		@(posedge clock) disable iff (!rst_n)
		(dec.conv && !ieb_q[FSB_CONV_EN_BIT]) |=> (!conversion_done_flag && conversion_clear))
		else $error("conversion flag not cleared");

	// Enable high: no skip, flag untouched.
	chk_conv_nop_hold: assert property (
		@(posedge clock) disable iff (!rst_n)
		(dec.conv && ieb_q[FSB_CONV_EN_BIT] && !conversion_set)
		|=> (!skip_request && conversion_done_flag == $past(conversion_done_flag)))
		else $error("conversion no-op disturbed state");

	// Select low: low pin skips.
	chk_pin_low_skip: assert property (
		@(posedge clock) disable iff (!rst_n)
		(dec.pin && !epc_q[FSB_LVL_SEL_BIT]) |=> (skip_request == !$past(pin_sync_q)))
		else $error("pin low skip wrong");

	// Select high: high pin skips.
	chk_pin_high_skip: assert property (
		@(posedge clock) disable iff (!rst_n)
		(dec.pin && epc_q[FSB_LVL_SEL_BIT]) |=> (skip_request == $past(pin_sync_q)))
		else $error("pin high skip wrong");

	// Standby opcode follows the indicator.
	chk_stby_skip_flag: assert property (
		@(posedge clock) disable iff (!rst_n)
		dec.stby |=> (skip_request == $past(standby_indicator)))
		else $error("standby skip wrong");

	// Serial skip follows the enabled set flag.
	chk_ser_skip_taken: assert property (
		@(posedge clock) disable iff (!rst_n)
		(dec.ser && !ieb_q[FSB_SER_EN_BIT] && serial_done_flag) |=> skip_request)
		else $error("serial skip not taken");

	// Serial flag cleared even when a set arrives together.
	chk_ser_flag_clear: assert property (
		@(posedge clock) disable iff (!rst_n)
		(dec.ser && !ieb_q[FSB_SER_EN_BIT]) |=> (!serial_done_flag && serial_clear))
		else $error("serial flag not cleared");

	// Serial enable high: no skip, no clear.
	chk_ser_nop_hold: assert property (
		@(posedge clock) disable iff (!rst_n)
		(dec.ser && serial_irq_enable) |=> (!skip_request && !serial_clear))
		else $error("serial no-op disturbed state");

	// The squashed instruction neither executes nor skips.
	chk_skip_squash_next: assert property (
		@(posedge clock) disable iff (!rst_n)
		(skip_pending && clk_en && instr_valid) |-> (dec == 4'h0) ##1 !skip_request)
		else $error("squashed instruction executed");

endmodule : fsb_unit

// ---- testbench/fsb_seq_model.sv ----
`timescale 1ns/1ps
module fsb_seq_model
	import fsb_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic skip_pending,
	input wire logic go,
	input wire logic [9:0] go_word,
	output logic instr_valid,
	output logic [9:0] instr_word,
	output logic squashed_q,
	output logic [7:0] pc_q
);
	// Issue step: 0 idle, 1 opcode in execute, 2 follower in execute.
	logic [1:0] step_q;

	// ----------------------------------------
	// Sequencer: opcode, then one follower that is dropped when pending.
	// ----------------------------------------
	// squash follower, count pc.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			step_q <= 2'h0;
			instr_valid <= 1'b0;
			instr_word <= 10'h000;
			squashed_q <= 1'b0;
			pc_q <= 8'h00;
		end else begin
			case (step_q)
			2'h0: if (go) begin
				instr_valid <= 1'b1;
				instr_word <= go_word;
				step_q <= 2'h1;
			end
			2'h1: begin
				// The follower repeats the opcode, so an execution that escapes the squash shows.
				pc_q <= pc_q + 8'h01;
				step_q <= 2'h2;
			end
			default: begin
				// The follower advances the counter even when it is dropped.
				instr_valid <= 1'b0;
				instr_word <= ~instr_word;
				squashed_q <= skip_pending;
				pc_q <= pc_q + 8'h01;
				step_q <= 2'h0;
			end
			endcase
		end
	end
endmodule : fsb_seq_model

// ---- testbench/tb_flag_skip_instruction_unit.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
	$display("Error %s exp %h got %h", nm, ex, got); end end
module tb_flag_skip_instruction_unit
	import fsb_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout, hresp;
	logic [31:0] hrdata, rd;
	logic instr_valid, skip_request, skip_pending, irq, squashed_q;
	logic [9:0] instr_word;
	logic [7:0] pc_q;
	logic go = 1'b0;
	logic [9:0] go_word = 10'h000;
	logic standby_indicator = 1'b0;
	logic conversion_set = 1'b0;
	logic serial_set = 1'b0;
	logic external_request_pin = 1'b0;
	logic conversion_done_flag, serial_done_flag, conversion_clear, serial_clear;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [9:0] opc;
	// Expected pair of clear strobes, conversion first.
	logic [1:0] clr_bit;

	always #2.5 clock = ~clock;

	fsb_unit uut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_valid(instr_valid),
		.instr_word(instr_word), .standby_indicator(standby_indicator),
		.skip_request(skip_request), .skip_pending(skip_pending),
		.conversion_set(conversion_set), .serial_set(serial_set),
		.external_request_pin(external_request_pin),
		.conversion_done_flag(conversion_done_flag), .serial_done_flag(serial_done_flag),
		.conversion_clear(conversion_clear), .serial_clear(serial_clear), .irq(irq));

	fsb_seq_model seq (.clock(clock), .rst_n(rst_n), .skip_pending(skip_pending), .go(go),
		.go_word(go_word), .instr_valid(instr_valid), .instr_word(instr_word),
		.squashed_q(squashed_q), .pc_q(pc_q));

	// ----------------------------------------
	// Bus and instruction tasks.
	// ----------------------------------------
	// One single AHB-Lite word transfer; read data is taken at the closing edge.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask : bus

	// Runs one opcode and its follower; clash raises the converter set with the opcode.
	task run(input logic [9:0] w, input logic clash, input logic skip, input logic [1:0] clr);
		logic [7:0] pc0;
		pc0 = pc_q;
		@(posedge clock);
		go <= 1'b1;
		go_word <= w;
		@(posedge clock);
		go <= 1'b0;
		conversion_set <= clash;
		@(posedge clock);
		conversion_set <= 1'b0;
		@(posedge clock);
		`CHK("skip_request", skip, skip_request)
		`CHK("clear strobes", clr, {conversion_clear, serial_clear})
		@(posedge clock);
		`CHK("skip", skip, squashed_q)
		`CHK("pc", pc0 + 8'h02, pc_q)
	endtask : run

	// Prints the counts and the verdict, then stops.
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Cuts a hung run short.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		// Every register reads zero after reset, an unmapped place too.
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 8'(4 * i), 32'h0000_0000);
			`CHK("reset value", 32'h0000_0000, rd)
		end
		// Both flag opcodes, every enable and flag combination.
		for (int k = 0; k < 2; k++) begin
			for (int e = 0; e < 2; e++) begin
				for (int f = 0; f < 2; f++) begin
					opc = (k == 1) ? FSB_OPC_SER : FSB_OPC_CONV;
					clr_bit = (k == 1) ? 2'b01 : 2'b10;
					bus(1'b1, FSB_REG_IEB, 32'(e) << ((k == 1) ? 3 : 2));
					@(posedge clock);
					conversion_set <= (f == 1 && k == 0);
					serial_set <= (f == 1 && k == 1);
					@(posedge clock);
					conversion_set <= 1'b0;
					serial_set <= 1'b0;
					run(opc, 1'b0, e == 0 && f == 1, clr_bit & {2{e == 0}});
					`CHK("flag", (e == 1 && f == 1), conversion_done_flag | serial_done_flag)
					bus(1'b1, FSB_REG_IEB, 32'h0000_0000);
					run(opc, 1'b0, e == 1 && f == 1, clr_bit);
				end
			end
		end
		// A converter set in the executing cycle loses to the opcode clear.
		@(posedge clock);
		conversion_set <= 1'b1;
		run(FSB_OPC_CONV, 1'b1, 1'b1, 2'b10);
		`CHK("clash flag", 1'b0, conversion_done_flag)
		// Pin opcode for both select levels and pin levels.
		for (int s = 0; s < 2; s++) begin
			for (int p = 0; p < 2; p++) begin
				bus(1'b1, FSB_REG_EPC, 32'(s) << 2);
				external_request_pin <= p[0];
				repeat (4) @(posedge clock);
				run(FSB_OPC_PIN, 1'b0, (s == 1) ? p == 1 : p == 0, 2'b00);
			end
		end
		// Standby opcode skips on the indicator and leaves it alone.
		for (int b = 0; b < 2; b++) begin
			standby_indicator <= b[0];
			run(FSB_OPC_STBY, 1'b0, b == 1, 2'b00);
			bus(1'b1, FSB_REG_FLG, 32'h0000_000F);
			bus(1'b0, FSB_REG_FLG, 32'h0000_0000);
			`CHK("flags", {28'h000_0000, 1'b1, b[0], 2'h0}, rd)
		end
		// Sticky status, mask and the level interrupt.
		bus(1'b0, FSB_REG_IST, 32'h0000_0000);
		`CHK("status", 32'h0000_0007, rd)
		`CHK("irq masked", 1'b0, irq)
		bus(1'b1, FSB_REG_IMK, 32'h0000_0001);
		repeat (2) @(posedge clock);
		`CHK("irq raised", 1'b1, irq)
		bus(1'b1, FSB_REG_IST, 32'h0000_0001);
		repeat (2) @(posedge clock);
		`CHK("irq cleared", 1'b0, irq)
		bus(1'b0, FSB_REG_IST, 32'h0000_0000);
		`CHK("status w1c", 32'h0000_0006, rd)
		bus(1'b1, 8'h20, 32'hFFFF_FFFF);
		bus(1'b0, 8'h20, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, rd)
		tally_and_finish();
	end
endmodule : tb_flag_skip_instruction_unit
